// ===== alc_pkg.sv
// Register map, field positions, reset values and carrier types.
package alc_pkg;
	// Byte address width of the register window on the bus.
	localparam int ADDR_W = 14;
	// Register indices; each register sits at four times its index.
	localparam logic [11:0] IDX_LEFT_LEVEL = 12'hb41;
	localparam logic [11:0] IDX_RIGHT_LEVEL = 12'hb42;
	localparam logic [11:0] IDX_CEILING = 12'hb43;
	localparam logic [11:0] IDX_UPPER = 12'hb44;
	localparam logic [11:0] IDX_LOWER = 12'hb46;
	localparam logic [11:0] IDX_NOISE = 12'hb48;
	localparam logic [11:0] IDX_LEFT_READBACK = 12'hb4d;
	localparam logic [11:0] IDX_RIGHT_READBACK = 12'hb4e;
	localparam logic [11:0] IDX_TICK_LO = 12'hb50;
	localparam logic [11:0] IDX_TICK_HI = 12'hb51;
	localparam logic [11:0] IDX_CONFIG = 12'hb54;
	localparam logic [11:0] IDX_COEF = 12'hb55;
	localparam logic [11:0] IDX_MASK = 12'hb56;
	localparam logic [11:0] IDX_RISE_RATE = 12'hb57;
	localparam logic [11:0] IDX_RISE_LIM = 12'hb58;
	localparam logic [11:0] IDX_FALL_RATE = 12'hb59;
	localparam logic [11:0] IDX_FALL_LIM = 12'hb5a;
	localparam logic [11:0] IDX_NOISE_RATE = 12'hb5b;
	localparam logic [11:0] IDX_NOISE_LIM = 12'hb5c;
	localparam logic [11:0] IDX_LEFT_AMP_NOW = 12'hb5e;
	localparam logic [11:0] IDX_RIGHT_AMP_NOW = 12'hb5f;
	localparam logic [11:0] IDX_JUDGE = 12'hb60;
	localparam logic [11:0] IDX_LEFT_GOAL = 12'hb61;
	localparam logic [11:0] IDX_LEFT_VALUE = 12'hb62;
	localparam logic [11:0] IDX_OVERRIDE = 12'hb63;
	localparam logic [11:0] IDX_SWAP = 12'hb64;
	localparam logic [11:0] IDX_RIGHT_GOAL = 12'hb65;
	localparam logic [11:0] IDX_RIGHT_VALUE = 12'hb66;
	// Storage slots, addressed by the low six bits of the index.
	localparam int NREG = 39;
	// Reset values.
	localparam logic [7:0] RST_LEVEL = 8'h20;
	localparam logic [7:0] RST_CEILING = 8'h33;
	localparam logic [7:0] RST_UPPER = 8'h60;
	localparam logic [7:0] RST_LOWER = 8'h40;
	localparam logic [7:0] RST_NOISE = 8'h02;
	localparam logic [7:0] RST_TICK_HI = 8'h02;
	localparam logic [7:0] RST_CONFIG = 8'h0a;
	localparam logic [7:0] RST_COEF = 8'hfa;
	localparam logic [7:0] RST_RISE_RATE = 8'h0a;
	localparam logic [7:0] RST_RISE_LIM = 8'h03;
	localparam logic [7:0] RST_FALL_RATE = 8'h08;
	localparam logic [7:0] RST_SIX = 8'h06;
	localparam logic [7:0] RST_JUDGE = 8'h40;
	localparam logic [7:0] RST_OVERRIDE = 8'h80;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Field positions.
	localparam int BIT_AUTO = 7;
	localparam int BIT_FIX = 7;
	localparam int BIT_MUTE = 7;
	localparam int BIT_SWAP = 0;
	localparam int CFG_ANALOG = 0;
	localparam int CFG_VAD_IIR = 1;
	localparam int CFG_ANA_IIR = 2;
	localparam int CFG_TICK_CLR = 3;
	localparam int CFG_VAD_MAX = 4;
	// Bus answers.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// One channel of measured input level.
	typedef struct packed {
		logic sample_valid;
		logic [6:0] level;
	} alc_chan_in_t;
	// One channel of gain controls towards the amplifier and datapath.
	typedef struct packed {
		logic [6:0] amp_gain;
		logic [6:0] dig_gain;
		logic mute;
		logic mask;
	} alc_chan_out_t;
endpackage

// ===== alc_gain_ctrl.sv
// Two-channel automatic level control with an AXI4-Lite register file.
// Summary of operation
// - Left bit7 auto; manual gain, auto floor
// - Right channel has identical independent control
// - Auto amplifier gain clamped to ceiling at each tick
// - Loop compares level with upper target
// - Loop compares level with lower target
// - Level under noise floor counts as noise
// - Sixteen-bit tick period paces adjustments
// - Config register holds five loop enables
// - Gain change masks programmed sample count
// - Rise per tick capped by rise limit
// - Fall per tick capped by fall limit
// - Noise uses own fall rate, limit
// - Readback: gain in auto, volume manual
// - Current amplifier gain readable per channel
// - Manual goal register with judgement-done flag
// - Judge rate paces manual approach
// - Bit7 mutes; readback shows amp value
// - Override bit forces fixed amplifier gain
// - Swap bit exchanges left and right amp gain and mute
//
// The implementer's own choice: register access over AXI4-Lite.
module alc_gain_ctrl (
	input logic clk,
	input logic reset_n,
	input logic [alc_pkg::ADDR_W-1:0] awaddr,
	input logic awvalid,
	output logic awready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	input logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input logic bready,
	input logic [alc_pkg::ADDR_W-1:0] araddr,
	input logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input logic rready,
	input alc_pkg::alc_chan_in_t left_in,
	input alc_pkg::alc_chan_in_t right_in,
	output alc_pkg::alc_chan_out_t left_out,
	output alc_pkg::alc_chan_out_t right_out
);
	import alc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Helpers.

	// Smaller of an eight-bit rate and a seven-bit limit.
	function automatic logic [6:0] min7(logic [7:0] a, logic [6:0] b);
		return (a < {1'b0, b}) ? a[6:0] : b;
	endfunction

	// One gain step, clamped to floor then ceiling, so the ceiling wins.
	function automatic logic [6:0] step_gain(logic [6:0] g, logic up,
		logic [6:0] s, logic [6:0] lo, logic [6:0] hi);
		logic [7:0] t;
		t = up ? {1'b0, g} + {1'b0, s} : {1'b0, g} - {1'b0, s};
		if (!up && s > g) begin
			t = 8'h00;
		end
		if (t < {1'b0, lo}) begin
			t = {1'b0, lo};
		end
		if (t > {1'b0, hi}) begin
			t = {1'b0, hi};
		end
		return t[6:0];
	endfunction

	// First-order smoother; larger k keeps more of the old average.
	function automatic logic [6:0] iir(logic [6:0] a, logic [6:0] x,
		logic [7:0] k);
		logic [15:0] s;
		s = {9'h000, a} * {8'h00, k} + {9'h000, x} * {8'h00, ~k};
		return s[14:8];
	endfunction

	// Registers that software may write.
	function automatic logic is_rw(logic [11:0] i);
		case (i)
			IDX_LEFT_LEVEL, IDX_RIGHT_LEVEL, IDX_CEILING, IDX_UPPER,
			IDX_LOWER, IDX_NOISE, IDX_TICK_LO, IDX_TICK_HI, IDX_CONFIG,
			IDX_COEF, IDX_MASK, IDX_RISE_RATE, IDX_RISE_LIM,
			IDX_FALL_RATE, IDX_FALL_LIM, IDX_NOISE_RATE, IDX_NOISE_LIM,
			IDX_JUDGE, IDX_LEFT_GOAL, IDX_LEFT_VALUE, IDX_OVERRIDE,
			IDX_SWAP, IDX_RIGHT_GOAL, IDX_RIGHT_VALUE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Bits kept on a write; goals keep 6:0, mute registers keep bit 7.
	function automatic logic [7:0] wmask(logic [11:0] i);
		case (i)
			IDX_LEFT_GOAL, IDX_RIGHT_GOAL: return 8'h7f;
			IDX_LEFT_VALUE, IDX_RIGHT_VALUE: return 8'h80;
			default: return 8'hff;
		endcase
	endfunction

	// Reset value of each storage slot.
	function automatic logic [7:0] rst_val(int s);
		case (6'(s))
			IDX_LEFT_LEVEL[5:0], IDX_RIGHT_LEVEL[5:0]: return RST_LEVEL;
			IDX_CEILING[5:0]: return RST_CEILING;
			IDX_UPPER[5:0]: return RST_UPPER;
			IDX_LOWER[5:0]: return RST_LOWER;
			IDX_NOISE[5:0]: return RST_NOISE;
			IDX_TICK_HI[5:0]: return RST_TICK_HI;
			IDX_CONFIG[5:0]: return RST_CONFIG;
			IDX_COEF[5:0]: return RST_COEF;
			IDX_RISE_RATE[5:0]: return RST_RISE_RATE;
			IDX_RISE_LIM[5:0]: return RST_RISE_LIM;
			IDX_FALL_RATE[5:0]: return RST_FALL_RATE;
			IDX_FALL_LIM[5:0], IDX_NOISE_RATE[5:0],
			IDX_NOISE_LIM[5:0]: return RST_SIX;
			IDX_JUDGE[5:0]: return RST_JUDGE;
			IDX_OVERRIDE[5:0]: return RST_OVERRIDE;
			default: return RST_ZERO;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// State.

	logic [7:0] regs_reg [NREG]; // Writable register storage.
	logic [7:0] regs_next [NREG];
	logic aw_full_reg, aw_full_next; // Write address held.
	logic w_full_reg, w_full_next; // Write data held.
	logic [11:0] widx_reg, widx_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wlane_reg, wlane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [7:0] rbyte_reg, rbyte_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [15:0] tick_reg, tick_next; // Peak tick down-counter.
	logic [7:0] judge_reg, judge_next; // Manual judge down-counter.
	logic [6:0] gain_reg [2], gain_next [2]; // Auto loop gain.
	logic [6:0] amp_reg [2], amp_next [2]; // Manual amplifier value.
	logic [6:0] avg_reg [2], avg_next [2]; // Smoothed level.
	logic [6:0] peak_reg [2], peak_next [2]; // Peak level this tick.
	logic [3:0] mask_reg [2], mask_next [2]; // Samples left to mask.
	alc_chan_out_t out_reg [2], out_next [2];

	// Combinational views.
	alc_chan_in_t cin [2];
	logic [7:0] set_w [2], goal_w [2];
	logic mute_w [2];
	logic [6:0] amp_eff [2], dig_eff [2], lvl_w [2];
	logic [7:0] cfg_w, fix_w, rd_val;
	logic [6:0] ceil_w, upper_w, lower_w, noise_w;
	logic [3:0] mcnt_w;
	logic [15:0] period_w;
	logic swap_w, tick_hit, judge_hit, wr_fire, rd_ok;
	logic [11:0] ridx;

	assign cin[0] = left_in;
	assign cin[1] = right_in;
	assign left_out = out_reg[0];
	assign right_out = out_reg[1];
	assign awready = !aw_full_reg;
	assign wready = !w_full_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = !rvalid_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = {24'h000000, rbyte_reg};
	assign ridx = araddr[ADDR_W-1:2];
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	assign cfg_w = regs_reg[IDX_CONFIG[5:0]];
	assign fix_w = regs_reg[IDX_OVERRIDE[5:0]];
	assign swap_w = regs_reg[IDX_SWAP[5:0]][BIT_SWAP];
	assign ceil_w = regs_reg[IDX_CEILING[5:0]][6:0];
	assign upper_w = regs_reg[IDX_UPPER[5:0]][6:0];
	assign lower_w = regs_reg[IDX_LOWER[5:0]][6:0];
	assign noise_w = regs_reg[IDX_NOISE[5:0]][6:0];
	assign mcnt_w = regs_reg[IDX_MASK[5:0]][3:0];
	assign period_w = {regs_reg[IDX_TICK_HI[5:0]],
		regs_reg[IDX_TICK_LO[5:0]]};
	assign tick_hit = tick_reg == 16'h0000;
	assign judge_hit = judge_reg == 8'h00;

	// Per-channel views; the two channels are fully independent.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			set_w[c] = regs_reg[c == 0 ? IDX_LEFT_LEVEL[5:0] :
				IDX_RIGHT_LEVEL[5:0]];
			goal_w[c] = regs_reg[c == 0 ? IDX_LEFT_GOAL[5:0] :
				IDX_RIGHT_GOAL[5:0]];
			mute_w[c] = regs_reg[c == 0 ? IDX_LEFT_VALUE[5:0] :
				IDX_RIGHT_VALUE[5:0]][BIT_MUTE];
			// Peak tracking or the smoothed level feeds the decision.
			lvl_w[c] = cfg_w[CFG_VAD_MAX] ? peak_reg[c] : avg_reg[c];
			// The override beats both the loop and the manual value.
			if (fix_w[BIT_FIX]) begin
				amp_eff[c] = fix_w[6:0];
			end else if (set_w[c][BIT_AUTO] && cfg_w[CFG_ANALOG]) begin
				amp_eff[c] = gain_reg[c];
			end else begin
				amp_eff[c] = amp_reg[c];
			end
			// Digital mode routes the loop gain to the datapath.
			if (set_w[c][BIT_AUTO] && !cfg_w[CFG_ANALOG]) begin
				dig_eff[c] = gain_reg[c];
			end else begin
				dig_eff[c] = {1'b0, set_w[c][5:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register read decode.

	// Read-only slots are built from live state, not from storage.
	always_comb begin
		rd_val = 8'h00;
		rd_ok = 1'b1;
		case (ridx)
			IDX_LEFT_READBACK: rd_val = {1'b0, set_w[0][BIT_AUTO] ?
				gain_reg[0] : {1'b0, set_w[0][5:0]}};
			IDX_RIGHT_READBACK: rd_val = {1'b0, set_w[1][BIT_AUTO] ?
				gain_reg[1] : {1'b0, set_w[1][5:0]}};
			IDX_LEFT_AMP_NOW: rd_val = {1'b0, amp_eff[0]};
			IDX_RIGHT_AMP_NOW: rd_val = {1'b0, amp_eff[1]};
			IDX_LEFT_GOAL: rd_val = {amp_reg[0] == goal_w[0][6:0],
				goal_w[0][6:0]};
			IDX_RIGHT_GOAL: rd_val = {amp_reg[1] == goal_w[1][6:0],
				goal_w[1][6:0]};
			IDX_LEFT_VALUE: rd_val = {mute_w[0], amp_reg[0]};
			IDX_RIGHT_VALUE: rd_val = {mute_w[1], amp_reg[1]};
			default: begin
				if (is_rw(ridx)) begin
					rd_val = regs_reg[ridx[5:0]];
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave and register storage.

	// Address and data are caught separately, then written together.
	always_comb begin
		regs_next = regs_reg;
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		widx_next = widx_reg;
		wbyte_next = wbyte_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rbyte_next = rbyte_reg;
		rresp_next = rresp_reg;
		if (awvalid && !aw_full_reg) begin
			aw_full_next = 1'b1;
			widx_next = awaddr[ADDR_W-1:2];
		end
		if (wvalid && !w_full_reg) begin
			w_full_next = 1'b1;
			wbyte_next = wdata[7:0];
			wlane_next = wstrb[0];
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		// A response is pending, so a new write waits for bready.
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = is_rw(widx_reg) ? RESP_OKAY : RESP_SLVERR;
			if (wlane_reg && is_rw(widx_reg)) begin
				regs_next[widx_reg[5:0]] = wbyte_reg & wmask(widx_reg);
			end
		end
		if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		if (arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rbyte_next = rd_val;
			rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Bus and storage flops.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int s = 0; s < NREG; s++) begin
				regs_reg[s] <= rst_val(s);
			end
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			widx_reg <= 12'h000;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rbyte_reg <= 8'h00;
			rresp_reg <= RESP_OKAY;
		end else begin
			regs_reg <= regs_next;
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			widx_reg <= widx_next;
			wbyte_reg <= wbyte_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rbyte_reg <= rbyte_next;
			rresp_reg <= rresp_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Level loop.

	// A tick clears the peak, so a sample in that cycle is not tracked.
	always_comb begin
		logic [6:0] src, stp;
		logic up, sc;
		src = 7'h00;
		stp = 7'h00;
		up = 1'b0;
		sc = 1'b0;
		tick_next = tick_hit ? period_w : tick_reg - 16'h0001;
		judge_next = judge_hit ? regs_reg[IDX_JUDGE[5:0]] :
			judge_reg - 8'h01;
		for (int c = 0; c < 2; c++) begin
			gain_next[c] = gain_reg[c];
			amp_next[c] = amp_reg[c];
			avg_next[c] = avg_reg[c];
			peak_next[c] = peak_reg[c];
			mask_next[c] = mask_reg[c];
			if (cin[c].sample_valid) begin
				avg_next[c] = cfg_w[CFG_ANA_IIR] ? iir(avg_reg[c],
					cin[c].level, regs_reg[IDX_COEF[5:0]]) :
					cin[c].level;
				src = cfg_w[CFG_VAD_IIR] ? avg_next[c] : cin[c].level;
				if (src > peak_reg[c]) begin
					peak_next[c] = src;
				end
				if (mask_reg[c] != 4'h0) begin
					mask_next[c] = mask_reg[c] - 4'h1;
				end
			end
			if (!set_w[c][BIT_AUTO]) begin
				// Manual: park the loop on the floor for a clean start.
				gain_next[c] = set_w[c][6:0];
			end else if (tick_hit) begin
				// A step left over from the other channel must not leak in.
				up = 1'b0;
				stp = 7'h00;
				if (lvl_w[c] < noise_w) begin
					stp = min7(regs_reg[IDX_NOISE_RATE[5:0]],
						regs_reg[IDX_NOISE_LIM[5:0]][6:0]);
				end else if (lvl_w[c] > upper_w) begin
					stp = min7(regs_reg[IDX_FALL_RATE[5:0]],
						regs_reg[IDX_FALL_LIM[5:0]][6:0]);
				end else if (lvl_w[c] < lower_w) begin
					up = 1'b1;
					stp = min7(regs_reg[IDX_RISE_RATE[5:0]],
						regs_reg[IDX_RISE_LIM[5:0]][6:0]);
				end
				// In band the zero step still pulls the gain inside limits,
				// so a lowered ceiling takes hold at the next tick.
				gain_next[c] = step_gain(gain_reg[c], up, stp,
					set_w[c][6:0], ceil_w);
				if (gain_next[c] != gain_reg[c]) begin
					mask_next[c] = mcnt_w;
				end
			end
			if (tick_hit) begin
				peak_next[c] = 7'h00;
				if (cfg_w[CFG_TICK_CLR]) begin
					avg_next[c] = 7'h00;
				end
			end
			// Manual judgement walks one step per judge period.
			if (judge_hit && amp_reg[c] != goal_w[c][6:0]) begin
				amp_next[c] = (amp_reg[c] < goal_w[c][6:0]) ?
					amp_reg[c] + 7'h01 : amp_reg[c] - 7'h01;
			end
			sc = (c == 1) ^ swap_w;
			out_next[c].amp_gain = amp_eff[sc];
			out_next[c].mute = mute_w[sc];
			out_next[c].dig_gain = dig_eff[c];
			out_next[c].mask = mask_reg[c] != 4'h0;
		end
	end

	// Loop flops.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tick_reg <= 16'h0000;
			judge_reg <= 8'h00;
			for (int c = 0; c < 2; c++) begin
				gain_reg[c] <= 7'h00;
				amp_reg[c] <= 7'h00;
				avg_reg[c] <= 7'h00;
				peak_reg[c] <= 7'h00;
				mask_reg[c] <= 4'h0;
				out_reg[c] <= '0;
			end
		end else begin
			tick_reg <= tick_next;
			judge_reg <= judge_next;
			gain_reg <= gain_next;
			amp_reg <= amp_next;
			avg_reg <= avg_next;
			peak_reg <= peak_next;
			mask_reg <= mask_next;
			out_reg <= out_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the left channel, plus the right output in a_fix; the right one shares the same logic.

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_manual_gain;
		!swap_w && !set_w[0][BIT_AUTO] |=>
			left_out.dig_gain == {1'b0, $past(set_w[0][5:0])};
	endproperty
	a_manual_gain: assert property (p_manual_gain)
		else $error("manual digital gain not passed through");

	property p_ceiling;
		set_w[0][BIT_AUTO] && tick_hit |=> gain_reg[0] <= $past(ceil_w);
	endproperty
	a_ceiling: assert property (p_ceiling)
		else $error("auto gain above ceiling");

	property p_reload;
		tick_hit |=> tick_reg == $past(period_w);
	endproperty
	a_reload: assert property (p_reload)
		else $error("tick counter not reloaded from period");

	property p_still;
		set_w[0][BIT_AUTO] && $past(set_w[0][BIT_AUTO]) &&
			!$past(tick_hit) |-> gain_reg[0] == $past(gain_reg[0]);
	endproperty
	a_still: assert property (p_still)
		else $error("auto gain moved between ticks");

	property p_mask;
		set_w[0][BIT_AUTO] && tick_hit && gain_next[0] != gain_reg[0]
			|=> mask_reg[0] == $past(mcnt_w) ##1 left_out.mask ==
			($past(mcnt_w, 2) != 4'h0);
	endproperty
	a_mask: assert property (p_mask)
		else $error("sample mask not loaded on gain change");

	property p_rise;
		set_w[0][BIT_AUTO] && tick_hit && gain_reg[0] >= set_w[0][6:0]
			|=> {1'b0, gain_reg[0]} <= {1'b0, $past(gain_reg[0])} +
			{1'b0, $past(regs_reg[IDX_RISE_LIM[5:0]][6:0])};
	endproperty
	a_rise: assert property (p_rise)
		else $error("gain rose more than rise limit");

	property p_fall;
		set_w[0][BIT_AUTO] && tick_hit && lvl_w[0] >= noise_w &&
			gain_reg[0] <= ceil_w |=> {1'b0, $past(gain_reg[0])} <=
			{1'b0, gain_reg[0]} +
			{1'b0, $past(regs_reg[IDX_FALL_LIM[5:0]][6:0])};
	endproperty
	a_fall: assert property (p_fall)
		else $error("gain fell more than fall limit");

	property p_noise;
		set_w[0][BIT_AUTO] && tick_hit && lvl_w[0] < noise_w &&
			gain_reg[0] <= ceil_w |=> {1'b0, $past(gain_reg[0])} <=
			{1'b0, gain_reg[0]} +
			{1'b0, $past(regs_reg[IDX_NOISE_LIM[5:0]][6:0])};
	endproperty
	a_noise: assert property (p_noise)
		else $error("noise fall exceeded noise limit");

	property p_loud;
		set_w[0][BIT_AUTO] && tick_hit && lvl_w[0] > upper_w &&
			gain_reg[0] >= set_w[0][6:0] && gain_reg[0] <= ceil_w
			|=> gain_reg[0] <= $past(gain_reg[0]);
	endproperty
	a_loud: assert property (p_loud)
		else $error("gain rose while level above upper target");

	property p_judge;
		judge_hit && amp_reg[0] != goal_w[0][6:0] |=>
			amp_reg[0] == $past(amp_reg[0]) + 7'h01 ||
			amp_reg[0] == $past(amp_reg[0]) - 7'h01;
	endproperty
	a_judge: assert property (p_judge)
		else $error("manual judgement did not step by one");

	property p_mute_write;
		wr_fire && wlane_reg && widx_reg == IDX_LEFT_VALUE |=>
			mute_w[0] == $past(wbyte_reg[BIT_MUTE]) ##1
			left_out.mute == (swap_w ? mute_w[1] : mute_w[0]);
	endproperty
	a_mute_write: assert property (p_mute_write)
		else $error("mute write not applied");

	property p_fix;
		fix_w[BIT_FIX] |=> left_out.amp_gain == $past(fix_w[6:0]) &&
			right_out.amp_gain == $past(fix_w[6:0]);
	endproperty
	a_fix: assert property (p_fix)
		else $error("override gain not forced");

	property p_swap;
		1'b1 |=> left_out.amp_gain ==
			(($past(swap_w)) ? $past(amp_eff[1]) : $past(amp_eff[0]));
	endproperty
	a_swap: assert property (p_swap)
		else $error("channel swap not applied");

	c_rise: cover property (set_w[0][BIT_AUTO] && tick_hit
		##1 gain_reg[0] > $past(gain_reg[0]));
	c_mask: cover property (left_out.mask && left_in.sample_valid);
	c_swap: cover property (swap_w && !fix_w[BIT_FIX]);
	c_done: cover property (judge_hit && amp_next[0] == goal_w[0][6:0]
		&& amp_reg[0] != goal_w[0][6:0]);
endmodule

// ===== alc_src_model.sv
// Partner model: measured-level source feeding both audio channels.
module alc_src_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [6:0] lvl_l,
	input wire logic [6:0] lvl_r,
	output alc_pkg::alc_chan_in_t left_in = '0,
	output alc_pkg::alc_chan_in_t right_in = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	import alc_pkg::*;
	// Phase toggle, so a fresh sample arrives every second cycle.
	logic ph = 1'b0;
	// Between samples the level bus shows the inverse of the level.
	// A stale value must never pass for a real measurement.
	always @(posedge clk) begin
		ph <= reset_n ? !ph : 1'b0;
		left_in.sample_valid <= ph;
		right_in.sample_valid <= ph;
		left_in.level <= ph ? lvl_l : ~lvl_l;
		right_in.level <= ph ? lvl_r : ~lvl_r;
	end
endmodule

// ===== alc_gain_ctrl_test.sv
// Self-checking testbench for the automatic level control block.
module alc_gain_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import alc_pkg::*;
	logic clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r;
	logic [6:0] lvl_l = 7'h10, lvl_r = 7'h10;
	logic seen_m = 0;
	logic [7:0] d;
	alc_chan_in_t left_in, right_in;
	alc_chan_out_t left_out, right_out;
	int miscompares = 0, n_checks = 0;
	logic [19:0] tab [$];
	alc_gain_ctrl DUT (
		.clk(clk),
		.reset_n(reset_n),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.left_in(left_in),
		.right_in(right_in),
		.left_out(left_out),
		.right_out(right_out)
	);
	alc_src_model src (
		.clk(clk),
		.reset_n(reset_n),
		.lvl_l(lvl_l),
		.lvl_r(lvl_r),
		.left_in(left_in),
		.right_in(right_in)
	);
	////////////////////////////////////////////////////////////////////
	// Clock at 20 MHz, and a watchdog sized well past the run length.
	initial forever #25 clk = !clk;
	initial begin
		#(10000 * 50);
		miscompares++;
		test_done();
	end
	// Remember whether the sample mask was ever raised on the left.
	always @(posedge clk) if (left_out.mask === 1'b1) seen_m <= 1'b1;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	// Write one register; address and data are offered together.
	task automatic wr(input logic [11:0] i, input logic [7:0] v);
		logic a, w;
		a = 1;
		w = 1;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (a || w) begin
			@(posedge clk);
			if (a && awready) begin a = 0; awvalid <= 0; end
			if (w && wready) begin w = 0; wvalid <= 0; end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		// Bready stays high, so a call right after this one never
		// lowers and raises it in the same time step.
		r = bresp;
	endtask
	task automatic rd(input logic [11:0] i);
		araddr <= {i, 2'h0};
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		chk("rdata_hi", rdata[31:8], 24'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic test_done();
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(40055));
		wt(6);
		reset_n <= 1;
		wt(1);
		// Reset values of sixteen of the writable registers.
		tab = '{20'hb4120, 20'hb4220, 20'hb4333, 20'hb4460, 20'hb4640,
			20'hb4802, 20'hb5000, 20'hb5102, 20'hb540a, 20'hb5a06,
			20'hb5803, 20'hb5b06, 20'hb5c06, 20'hb6040, 20'hb6380,
			20'hb6400};
		foreach (tab[k]) begin
			rd(tab[k][19:8]);
			chk("reset", d, tab[k][7:0]);
		end
		// Unmapped read and a write to a read-only place are refused.
		rd(12'hb45);
		chk("unmapped", {r, d}, 10'h200);
		wr(12'hb4d, 8'h55);
		chk("ro_write", r, RESP_SLVERR);
		// A write without byte lane 0 is answered but changes nothing.
		wstrb <= 4'he;
		wr(12'hb60, 8'h11);
		wstrb <= 4'hf;
		rd(12'hb60);
		chk("no_lane", {r, d}, 10'h040);
		// Random data written to five of the registers and read straight back.
		tab = '{20'hb4400, 20'hb4600, 20'hb4800, 20'hb5700, 20'hb5b00};
		foreach (tab[k]) begin
			tab[k][7:0] = 8'($urandom);
			wr(tab[k][19:8], tab[k][7:0]);
			rd(tab[k][19:8]);
			chk("rw", d, tab[k][7:0]);
		end
		// Manual mode: bits 5:0 set the digital gain of each channel.
		wr(12'hb41, 8'h2a);
		wr(12'hb42, 8'h15);
		wt(4);
		chk("man_l", left_out.dig_gain, 7'h2a);
		chk("man_r", right_out.dig_gain, 7'h15);
		rd(12'hb4d);
		chk("vol_rb", d, 8'h2a);
		// Fixed gain override on a random value.
		d = 8'($urandom) | 8'h80;
		wr(12'hb63, d);
		wt(4);
		chk("fix_l", left_out.amp_gain, d[6:0]);
		chk("fix_r", right_out.amp_gain, d[6:0]);
		// Mute the left channel, then swap the channels.
		wr(12'hb62, 8'h80);
		wt(4);
		chk("mute", left_out.mute, 1'b1);
		wr(12'hb64, 8'h01);
		wt(4);
		chk("swap", {left_out.mute, right_out.mute}, 2'b01);
		// Manual judgement walks to the goal one step per judge period.
		wr(12'hb61, 8'h05);
		wt(400);
		rd(12'hb61);
		chk("goal", d, 8'h85);
		rd(12'hb62);
		chk("amp_val", d, 8'h85);
		// Automatic analog loop: clamp the parked gain down to the ceiling, then noise fall.
		tab = '{20'hb6300, 20'hb6400, 20'hb6200, 20'hb5020, 20'hb5100,
			20'hb4314, 20'hb4460, 20'hb4640, 20'hb4802, 20'hb5401,
			20'hb5603, 20'hb5b06, 20'hb4190};
		foreach (tab[k]) wr(tab[k][19:8], tab[k][7:0]);
		wt(1000);
		chk("ceil", left_out.amp_gain, 7'h14);
		rd(12'hb5e);
		chk("amp_rb", d, 8'h14);
		chk("mask", seen_m, 1'b1);
		lvl_l <= 7'h00;
		wt(1000);
		chk("floor", left_out.amp_gain, 7'h10);
		rd(12'hb4d);
		chk("gain_rb", d, 8'h10);
		chk("mask_r", right_out.mask, 1'b0);
		test_done();
	end
endmodule
